/* File: hw/acr_top.sv */
`timescale 1ns/1ps

module acr_top
(
  input wire logic core_clk_in, // Peripheral clock, 25 MHz
  input wire logic arst_n_in, // Async reset, active low
  input wire logic [acr_pkg::ADDR_W-1:0] addr_in, // Register address
  input wire logic [acr_pkg::DATA_W-1:0] wr_data_in, // Write data
  input wire logic wr_en_in, // Write strobe
  input wire logic rd_en_in, // Read strobe
  output logic [acr_pkg::DATA_W-1:0] rd_data_out, // Read data, next cycle
  input wire logic cmp_raw_in, // Raw comparator result from core
  input wire logic sleep_standby_in, // Standby sleep active
  input wire logic sleep_powerdown_in, // Power-down sleep active
  output logic cmp_enable_out, // Comparator core on
  output logic low_current_out, // Reduced-current request
  output logic [1:0] hysteresis_level_out, // Hysteresis select
  output logic positive_select_out, // Positive input select
  output logic [1:0] negative_input_select_out, // Negative input select
  output logic pad_out, // Result to output pin
  output logic pad_oe_out, // Pin driven by comparator
  output logic event_out, // Result to event routing
  output logic irq_out // Interrupt request, level
);
  import acr_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] mux_r;
  logic [DATA_W-1:0] inten_r;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic [DATA_W-1:0] status_view;
  logic flag_r;
  logic flag_nxt;
  logic state_r;
  logic sync_level;
  logic cmp_result;
  logic analog_on;
  logic edge_pulse;
  logic flag_clr;
  logic wr_ctrl;
  logic wr_mux;
  logic wr_inten;
  logic wr_status;
  logic rd_status;
  logic enable_bit;
  logic runstby_bit;
  logic pad_bit;
  logic invert_bit;
  acr_edge_t edge_mode;

  // ****************************************
  // Field views
  // ****************************************
  assign enable_bit = ctrl_r[CTRL_ENABLE_BIT];
  assign runstby_bit = ctrl_r[CTRL_RUNSTBY_BIT];
  assign pad_bit = ctrl_r[CTRL_PAD_BIT];
  assign invert_bit = mux_r[MUX_INVERT_BIT];
  assign edge_mode = acr_edge_t'(ctrl_r[CTRL_EDGE_LSB +: 2]);

  // ****************************************
  // Address decode
  // ****************************************
  always_comb
  begin
    wr_ctrl = 1'b0;
    wr_mux = 1'b0;
    wr_inten = 1'b0;
    wr_status = 1'b0;
    if (addr_in == OFF_CTRL)
      wr_ctrl = wr_en_in;
    else if (addr_in == OFF_MUX)
      wr_mux = wr_en_in;
    else if (addr_in == OFF_INTEN)
      wr_inten = wr_en_in;
    else if (addr_in == OFF_STATUS)
      wr_status = wr_en_in;
  end

  assign rd_status = rd_en_in && (addr_in == OFF_STATUS);

  // ****************************************
  // Software registers
  // ****************************************
  // Control register, all bits writable
  // reset and enable store
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ctrl_r <= CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= wr_data_in;
  end

  // Input select register, unused bits stay zero
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      mux_r <= MUX_RST;
    else if (wr_mux)
      mux_r <= wr_data_in & MUX_WMASK;
  end

  // Interrupt enable register, acts as the mask
  // enable bit store
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      inten_r <= INTEN_RST;
    else if (wr_inten)
      inten_r <= wr_data_in & INTEN_WMASK;
  end

  // ****************************************
  // Comparator path
  // ****************************************
  // raw result, inverted when the invert bit of the input select register is set
  assign cmp_result = cmp_raw_in ^ invert_bit;

  // Core runs unless halted by sleep or disabled
  // enable drive
  // standby keeps core only with run bit
  assign analog_on = enable_bit && !sleep_powerdown_in
    && !(sleep_standby_in && !runstby_bit);

  assign cmp_enable_out = analog_on;

  // Analog settings straight from the control and input select fields; positive select fixed to POS_PIN0
  // low-current request
  assign low_current_out = ctrl_r[CTRL_LOWCUR_BIT];
  assign hysteresis_level_out = ctrl_r[CTRL_HYS_LSB +: 2];
  assign positive_select_out = POS_PIN0;
  assign negative_input_select_out = mux_r[MUX_NEG_LSB +: 2];

  // Pad and event follow the result without the clock, so they work in standby
  // pad drive gate
  assign pad_oe_out = pad_bit && analog_on;
  assign pad_out = pad_oe_out && cmp_result;
  assign event_out = analog_on && cmp_result;

  // ****************************************
  // Synchroniser and state bit
  // ****************************************
  acr_sync u_sync
  (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .level_in(cmp_result),
    .level_out(sync_level)
  );

  // Third stage is the visible state; frozen while the clock is stopped
  // three-cycle lag
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_r <= 1'b0;
    else if (!sleep_standby_in)
      state_r <= sync_level;
  end

  // ****************************************
  // Edge detection and interrupt flag
  // ****************************************
  // edges on synchronised level, armed by enable
  acr_edge u_edge
  (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .level_in(state_r),
    .hold_in(sleep_standby_in),
    .arm_in(enable_bit),
    .mode_in(edge_mode),
    .pulse_out(edge_pulse)
  );

  // Clear by writing one, or by reading status
  // write-one clear
  assign flag_clr = (wr_status && wr_data_in[STAT_FLAG_BIT]) || rd_status;

  // Set wins over a clear in the same cycle
  always_comb
  begin
    flag_nxt = flag_r;
    if (flag_clr)
      flag_nxt = 1'b0;
    if (edge_pulse)
      flag_nxt = 1'b1;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  // Level request while flag and enable are set
  // request level
  assign irq_out = flag_r && inten_r[INTEN_IRQ_BIT];

  // ****************************************
  // Read path
  // ****************************************
  // Status layout, unused bits read zero
  always_comb
  begin
    status_view = '0;
    status_view[STAT_STATE_BIT] = state_r;
    status_view[STAT_FLAG_BIT] = flag_r;
  end

  // Read mux, unmapped addresses give zero
  always_comb
  begin
    rd_data_nxt = '0;
    if (addr_in == OFF_CTRL)
      rd_data_nxt = ctrl_r;
    else if (addr_in == OFF_MUX)
      rd_data_nxt = mux_r;
    else if (addr_in == OFF_INTEN)
      rd_data_nxt = inten_r;
    else if (addr_in == OFF_STATUS)
      rd_data_nxt = status_view;
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rd_data_r <= '0;
    else if (rd_en_in)
      rd_data_r <= rd_data_nxt;
    else
      rd_data_r <= '0;
  end

  assign rd_data_out = rd_data_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // core on follows enable when awake
  chk_enable_core_on: assert property (
    (enable_bit && !sleep_standby_in && !sleep_powerdown_in) |-> cmp_enable_out)
    else $error("core not on while enabled");

  chk_disable_core_off: assert property (
    !enable_bit |-> (!cmp_enable_out && !event_out && !pad_oe_out))
    else $error("core active while disabled");

  // standby freezes the flag and halts a core without run bit
  chk_standby_freeze: assert property (
    (sleep_standby_in && !wr_en_in && !rd_en_in)
      |=> (flag_r == $past(flag_r) && state_r == $past(state_r)))
    else $error("status changed in standby");

  chk_standby_halt: assert property (
    (sleep_standby_in && !runstby_bit) |-> !cmp_enable_out)
    else $error("core on in standby without run");

  // pad shows the result while driven
  chk_pad_follow: assert property (
    pad_oe_out |-> (pad_out == (cmp_raw_in ^ invert_bit)))
    else $error("pad not equal to result");

  // rising mode sets the flag on a rise
  chk_rise_sets: assert property (
    ($rose(state_r) && enable_bit && !sleep_standby_in && edge_mode == ACR_EDGE_RISE)
      |=> flag_r)
    else $error("rise missed");

  chk_fall_ignored: assert property (
    ($fell(state_r) && !flag_r && edge_mode == ACR_EDGE_RISE) |=> !flag_r)
    else $error("fall set flag in rise mode");

  chk_rsvd_quiet: assert property (
    (!flag_r && edge_mode == ACR_EDGE_RSVD) |=> !flag_r)
    else $error("reserved mode set flag");

  chk_invert_event: assert property (
    (cmp_enable_out && invert_bit) |-> (event_out == !cmp_raw_in))
    else $error("event not inverted");

  // state bit lags the result by three cycles
  chk_state_lag: assert property (
    (!sleep_standby_in) [*4] |-> (state_r == $past(cmp_result, STATE_LAG_CYCLES)))
    else $error("state lag wrong");

  // write one clears, write zero keeps
  chk_flag_clear: assert property (
    (wr_status && wr_data_in[STAT_FLAG_BIT] && !edge_pulse) |=> !flag_r)
    else $error("flag not cleared");

  chk_flag_keep: assert property (
    (wr_status && !wr_data_in[STAT_FLAG_BIT] && flag_r) |=> flag_r)
    else $error("flag lost on write zero");

  // request holds until the flag is cleared
  chk_irq_hold: assert property (
    (irq_out && !flag_clr && !wr_inten) |=> irq_out)
    else $error("request dropped early");

  // event tracks the result while enabled
  chk_event_follow: assert property (
    cmp_enable_out |-> (event_out == cmp_result))
    else $error("event not following result");

  chk_powerdown_off: assert property (
    sleep_powerdown_in |-> (!cmp_enable_out && !pad_oe_out))
    else $error("active in power-down");

  chk_disabled_quiet: assert property (
    (!enable_bit && !flag_r) |=> !flag_r)
    else $error("flag set while disabled");

  // status view read back one cycle later
  chk_read_status: assert property (
    rd_status |=> (rd_data_out == {3'h0, $past(state_r), 3'h0, $past(flag_r)}))
    else $error("status read wrong");

  // Main scenarios
  cov_flag_set: cover property (!flag_r ##1 flag_r);
  cov_irq_clear: cover property (irq_out ##1 wr_status ##1 !irq_out);
  cov_standby_run: cover property (sleep_standby_in && cmp_enable_out && pad_oe_out);
  cov_fall_mode: cover property (edge_mode == ACR_EDGE_FALL && edge_pulse);

endmodule // acr_top

/* File: hw/acr_pkg.sv */
package acr_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_MUX = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_INTEN = 3'h6;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 3'h7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_HYS_LSB = 1;
  localparam int CTRL_LOWCUR_BIT = 3;
  localparam int CTRL_EDGE_LSB = 4;
  localparam int CTRL_PAD_BIT = 6;
  localparam int CTRL_RUNSTBY_BIT = 7;
  localparam int MUX_NEG_LSB = 0;
  localparam int MUX_INVERT_BIT = 7;
  localparam int INTEN_IRQ_BIT = 0;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_STATE_BIT = 4;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] MUX_RST = 8'h00;
  localparam logic [DATA_W-1:0] INTEN_RST = 8'h00;
  localparam logic [DATA_W-1:0] MUX_WMASK = 8'h83;
  localparam logic [DATA_W-1:0] INTEN_WMASK = 8'h01;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    ACR_EDGE_ANY = 2'h0,
    ACR_EDGE_RSVD = 2'h1,
    ACR_EDGE_FALL = 2'h2,
    ACR_EDGE_RISE = 2'h3
  } acr_edge_t;

  localparam logic [1:0] NEG_PIN0 = 2'h0;
  localparam logic [1:0] NEG_VREF = 2'h2;
  localparam logic [1:0] NEG_CONV = 2'h3;
  localparam logic [1:0] HYS_OFF = 2'h0;
  localparam logic POS_PIN0 = 1'b0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYNC_STAGES = 2;
  localparam int STATE_LAG_CYCLES = 3;

endpackage

/* File: hw/acr_sync.sv */
`timescale 1ns/1ps

// ****************************************
// Level synchroniser, fixed depth
// ****************************************
module acr_sync
(
  input wire logic core_clk_in, // Peripheral clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic level_in, // Level to synchronise
  output logic level_out // Synchronised level
);
  import acr_pkg::*;

  logic [SYNC_STAGES-1:0] stage_r;

  // Shift chain, each stage read only by the next one
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_STAGES; gi++)
    begin : g_stage
      always_ff @(posedge core_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
          stage_r[gi] <= 1'b0;
        else if (gi == 0)
          stage_r[gi] <= level_in;
        else
          stage_r[gi] <= stage_r[(gi == 0) ? 0 : gi-1];
      end
    end
  endgenerate

  assign level_out = stage_r[SYNC_STAGES-1];

endmodule // acr_sync

/* File: hw/acr_edge.sv */
`timescale 1ns/1ps

// ****************************************
// Edge detector with selectable polarity
// ****************************************
module acr_edge
(
  input wire logic core_clk_in, // Peripheral clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic level_in, // Synchronised comparator level
  input wire logic hold_in, // Clock stopped, freeze history
  input wire logic arm_in, // Detection allowed
  input wire acr_pkg::acr_edge_t mode_in, // Edge selection
  output logic pulse_out // One-cycle edge pulse
);
  import acr_pkg::*;

  logic prev_r;
  logic rise;
  logic fall;

  // History of the level, frozen while the clock is stopped
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      prev_r <= 1'b0;
    else if (!hold_in)
      prev_r <= level_in;
  end

  assign rise = level_in & ~prev_r;
  assign fall = ~level_in & prev_r;

  // Pick the edges that count; reserved mode never fires
  always_comb
  begin
    pulse_out = 1'b0;
    if (arm_in && !hold_in)
    begin
      case (mode_in)
        ACR_EDGE_ANY: pulse_out = rise | fall;
        ACR_EDGE_FALL: pulse_out = fall;
        ACR_EDGE_RISE: pulse_out = rise;
        default: pulse_out = 1'b0;
      endcase
    end
  end

endmodule // acr_edge

/* File: sim/acr_core_model.sv */
`timescale 1ns/1ps

// ****************************************
// Analog comparator core, behavioural
// ****************************************
module acr_core_model
(
  input wire logic enable_in, // Core on
  input wire logic low_current_in, // Reduced current
  input wire logic pos_sel_in, // Positive select
  input wire logic [1:0] neg_sel_in, // Negative select
  input wire logic [7:0] pos_lvl_in, // Positive pin level
  input wire logic [7:0] neg_lvl_in, // Negative pin level
  input wire logic [7:0] vref_lvl_in, // Reference level
  input wire logic [7:0] conv_lvl_in, // Converter level
  output logic raw_out // Raw result
);
  logic [7:0] neg_lvl;

  always_comb
  begin
    case (neg_sel_in)
      2'h2: neg_lvl = vref_lvl_in;
      2'h3: neg_lvl = conv_lvl_in;
      default: neg_lvl = neg_lvl_in;
    endcase
  end

  // result with slower reaction at low current
  always @(enable_in, pos_lvl_in, neg_lvl, low_current_in, pos_sel_in)
  begin
    if (enable_in)
      raw_out <= #(low_current_in ? 20 : 5) (pos_sel_in == 1'b0) && (pos_lvl_in > neg_lvl);
  end

  // switch-off flips the output; the start-up step of enable is no switch-off
  always @(negedge enable_in)
  begin
    if ($time > 0)
      raw_out <= ~raw_out;
  end
  initial raw_out = 1'b0;
endmodule // acr_core_model

/* File: sim/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  import acr_pkg::*;
  logic core_clk, arst_n, wr_en, rd_en, standby, pdown;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic raw, cmp_en, lowc, pos_sel, pad, pad_oe, evt, irq;
  logic [1:0] hys, neg_sel;
  logic [7:0] pos_lvl, neg_lvl, vref_lvl, conv_lvl;
  logic [2:0] offs [4] = '{OFF_CTRL, OFF_MUX, OFF_INTEN, OFF_STATUS};
  int errors, total_checks;

  acr_top acr_top_i (.core_clk_in(core_clk), .arst_n_in(arst_n), .addr_in(addr),
    .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
    .cmp_raw_in(raw), .sleep_standby_in(standby), .sleep_powerdown_in(pdown),
    .cmp_enable_out(cmp_en), .low_current_out(lowc), .hysteresis_level_out(hys),
    .positive_select_out(pos_sel), .negative_input_select_out(neg_sel),
    .pad_out(pad), .pad_oe_out(pad_oe), .event_out(evt), .irq_out(irq));

  acr_core_model acr_core_model_i (.enable_in(cmp_en), .low_current_in(lowc),
    .pos_sel_in(pos_sel), .neg_sel_in(neg_sel), .pos_lvl_in(pos_lvl),
    .neg_lvl_in(neg_lvl), .vref_lvl_in(vref_lvl), .conv_lvl_in(conv_lvl), .raw_out(raw));

  // ****************************************
  // Helpers
  // ****************************************
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Wait n edges, then let updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One-cycle register write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  // One-cycle register read, data in following cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, what);
  endtask
  // Positive pin level change at an edge
  task automatic drive(input logic [7:0] v);
    @(posedge core_clk);
    pos_lvl <= v;
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial
  begin
    #400000;
    errors++;
    $display("Error at %0t: run timed out", $time);
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [7:0] d;
    errors = 0;
    total_checks = 0;
    arst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wdata = '0;
    standby = 1'b0;
    pdown = 1'b0;
    pos_lvl = 8'h64;
    neg_lvl = 8'h32;
    vref_lvl = 8'h96;
    conv_lvl = 8'h50;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    tick(1);
    chk({cmp_en, pad_oe, irq, evt, lowc, hys}, 8'h00, "outputs after reset");
    foreach (offs[i]) rdchk(offs[i], 8'h00, "reset value");
    $display("Test reset done");
    for (int h = 0; h < 4; h++)
    begin
      wr(OFF_CTRL, 8'h08 | 8'(h << 1));
      rdchk(OFF_CTRL, 8'h08 | 8'(h << 1), "ctrl readback");
      chk({lowc, hys}, 8'h04 | 8'(h), "core config");
    end
    wr(OFF_MUX, 8'hff);
    rdchk(OFF_MUX, 8'h83, "mux readback");
    wr(OFF_INTEN, 8'hff);
    rdchk(OFF_INTEN, 8'h01, "inten readback");
    wr(3'h1, 8'hff);
    rdchk(3'h1, 8'h00, "unmapped read");
    $display("Test registers done");
    wr(OFF_CTRL, 8'h41);
    for (int n = 0; n < 4; n++)
    begin
      wr(OFF_MUX, 8'(n));
      tick(1);
      chk({pos_sel, neg_sel}, 8'(n), "input select");
      chk({pad_oe, pad, evt}, (n == 2) ? 8'h04 : 8'h07, "routing");
    end
    wr(OFF_MUX, 8'h80);
    tick(5);
    chk({pad_oe, pad, evt}, 8'h04, "inverted result");
    rd(OFF_STATUS, d);
    chk(d & 8'h10, 8'h00, "inverted state");
    wr(OFF_MUX, 8'h00);
    wr(OFF_CTRL, 8'h01);
    tick(1);
    chk({pad_oe, pad, evt}, 8'h01, "pad off");
    wr(OFF_CTRL, 8'h00);
    tick(1);
    chk({cmp_en, evt}, 8'h00, "disabled");
    $display("Test routing done");
    for (int m = 0; m < 4; m++)
    begin
      drive(8'h10);
      wr(OFF_CTRL, 8'h01 | 8'(m << 4));
      tick(6);
      wr(OFF_STATUS, 8'h01);
      tick(1);
      chk(irq, 8'h00, "irq cleared");
      drive(8'h64);
      tick(6);
      chk(irq, 8'(m == 0 || m == 3), "rise flag");
      wr(OFF_STATUS, 8'h01);
      drive(8'h10);
      tick(6);
      chk(irq, 8'(m == 0 || m == 2), "fall flag");
    end
    $display("Test edge modes done");
    wr(OFF_CTRL, 8'h01);
    wr(OFF_STATUS, 8'h01);
    drive(8'h64);
    tick(16);
    chk(irq, 8'h01, "irq held");
    wr(OFF_STATUS, 8'h00);
    tick(1);
    chk(irq, 8'h01, "write zero keeps flag");
    wr(OFF_INTEN, 8'h00);
    tick(1);
    chk(irq, 8'h00, "irq masked");
    wr(OFF_INTEN, 8'h01);
    tick(1);
    chk(irq, 8'h01, "irq unmasked");
    wr(OFF_STATUS, 8'h01);
    tick(1);
    chk(irq, 8'h00, "write one clears");
    drive(8'h10);
    tick(6);
    rdchk(OFF_STATUS, 8'h01, "status after fall");
    chk(irq, 8'h00, "read clears flag");
    drive(8'h64);
    tick(1);
    rd(OFF_STATUS, d);
    chk(d & 8'h10, 8'h00, "state before lag");
    rd(OFF_STATUS, d);
    chk(d & 8'h10, 8'h10, "state after lag");
    $display("Test interrupt done");
    tick(6);
    wr(OFF_STATUS, 8'h01);
    wr(OFF_CTRL, 8'h00);
    tick(8);
    chk(irq, 8'h00, "no flag while off");
    wr(OFF_CTRL, 8'h81);
    tick(6);
    wr(OFF_STATUS, 8'h01);
    @(posedge core_clk);
    standby <= 1'b1;
    tick(1);
    chk(cmp_en, 8'h01, "runs in standby");
    drive(8'h10);
    tick(6);
    chk({evt, irq}, 8'h00, "standby event, no irq");
    rdchk(OFF_STATUS, 8'h10, "status frozen");
    @(posedge core_clk);
    standby <= 1'b0;
    wr(OFF_CTRL, 8'h41);
    @(posedge core_clk);
    standby <= 1'b1;
    tick(1);
    chk({cmp_en, pad_oe}, 8'h00, "halted in standby");
    @(posedge core_clk);
    standby <= 1'b0;
    pdown <= 1'b1;
    tick(1);
    chk({cmp_en, pad_oe}, 8'h00, "power-down");
    @(posedge core_clk);
    pdown <= 1'b0;
    $display("Test sleep done");
    wrap_up();
  end
endmodule // tb_top
